/* wcp_defs.vh */
// constants for the water cooling pulse output block
`ifndef WCP_DEFS_VH
`define WCP_DEFS_VH
// register byte offsets
`define WCP_CTRL_OFS      8'h00
`define WCP_FUNC_OFS      8'h04
`define WCP_FMASK_OFS     8'h08
`define WCP_FVAL_OFS      8'h0C
`define WCP_AFORCE_OFS    8'h10
`define WCP_PULSE_OFS     8'h14
`define WCP_PSET1_OFS     8'h18
`define WCP_PSET2_OFS     8'h1C
`define WCP_YLIM_OFS      8'h20
`define WCP_YOFS_OFS      8'h24
`define WCP_STAT_OFS      8'h28
`define WCP_AOUT_OFS      8'h2C
// control register fields
`define WCP_CTRL_WC_EN    0
`define WCP_CTRL_AUTO     1
`define WCP_CTRL_AOPT     2
`define WCP_CTRL_LIVE0    3
`define WCP_CTRL_ALLOC    4
`define WCP_CTRL_PSEL     5
`define WCP_CTRL_VER_LO   8
`define WCP_CTRL_VER_HI   11
`define WCP_CTRL_RST      32'h0000_0022
// controller function codes
`define WCP_FN_OFF        3'h0
`define WCP_FN_SIG1       3'h1
`define WCP_FN_TWOPT      3'h2
`define WCP_FN_3PT_SC     3'h3
`define WCP_FN_3PT_CC     3'h4
`define WCP_FN_CONT       3'h5
`define WCP_FN_STEP       3'h6
// analog force needs this operating version or later
`define WCP_MIN_VERSION   4'h5
// percent values in 0.1 % units
`define WCP_PCT_FULL      10'h3E8
`define WCP_PCT_HALF      10'h1F4
`define WCP_YMIN_RST      10'h000
`define WCP_YMAX_RST      10'h3E8
`define WCP_Y0_RST        10'h000
// live zero offset: 4 mA of 20 mA in 0.02 mA steps
`define WCP_LIVE0_BASE    10'h0C8
// times in 0.1 s units
`define WCP_PULSE_OFF     14'h0000
`define WCP_PULSE_STEPMAX 14'h0014
`define WCP_PULSE_WCMAX   14'h270F
`define WCP_TIME_RST      14'h0032
`define WCP_TN_RST        14'h0064
// scanning interval 0.0625 s at 200 MHz
`define WCP_TICK_NS       62500000
`define WCP_CLK_NS        5
`define WCP_TICK_CYCLES   (`WCP_TICK_NS / `WCP_CLK_NS)
// pulse state codes
`define WCP_ST_IDLE       2'h0
`define WCP_ST_ON         2'h1
`define WCP_ST_OFF        2'h2
`endif

/* wcp_pulse_output.v */
// water cooling pulse output stage with forcing and continuous output
//
// Summary of operation
// - only outputs are forcible: heating 1-8, cooling 9-12, combined 13-16.
// - heating forcing only when off, three-point variant or continuous.
// - cooling forcing when off, signaller, two-point, three-point, continuous.
// - analog forcing needs option fitted, version five or more, no alloc.
// - one shared dead-zero or live-zero range for all analog outputs.
// - at most eight outputs act as continuous controller outputs.
// - two parameter sets per controller, selected as set one or two.
// - output clamped to min/max limits; limits and offset 0 to 100 %.
// - PD with zero integral time gives 50 % plus offset at zero error.
// - continuous output is a linear level, not a duty cycle.
// - water cooling enabled or disabled per channel by configuration.
// - cooling suppressed below enable temperature only in automatic mode.
// - constant on-pulses with a minimum off-pulse between them.
// - effective cooling is on-time over on-time plus off-time.
// - pulse length 0.1-2.0 s or off stepping, 0.1-999.9 s water cooling.
// - pulse times rounded up to whole 0.0625 s scanning intervals.
// - disabled pulse length means one scanning interval in water cooling.
// - reconfiguring to a function that invalidates pulse sets it off.
// - second min cycle time is the off-time at full cooling demand.
// - cooling demand is a fraction 0..1 for 0 % to -100 %.
// - full demand gives on-time over on-time plus minimum off-time.
//
// Decided for this implementation: the APB slave port and the address map.
`include "wcp_defs.vh"
module wcp_pulse_output #(
  parameter TICK_CYCLES = `WCP_TICK_CYCLES
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // controller side
  input  wire signed [11:0] corr_in,
  input  wire        below_enable_temp,
  input  wire [7:0]  heat_sw_in,
  input  wire [7:0]  cool_sw_in,
  // pins
  output reg  [7:0]  heating_outputs,
  output reg  [3:0]  cooling_outputs,
  output reg  [3:0]  combined_io_lines,
  output reg  [9:0]  analog_level,
  output reg         cooling_pulse
);

  // last divider count; kept 32 bits to match the counter
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // tenths of a second to whole ticks, rounded up; off counts one tick
  function [14:0] to_ticks;
    input [13:0] tenths;
    reg   [17:0] scaled;
    reg   [17:0] quot;
    begin
      scaled = ({4'h0, tenths} * 18'd8) + 18'd4;
      quot   = scaled / 18'd5;
      if (tenths == `WCP_PULSE_OFF)
        to_ticks = 15'd1;
      else if (quot[17:15] != 3'b000)
        to_ticks = 15'h7FFF;
      else
        to_ticks = quot[14:0];
    end
  endfunction

  // pulse value valid for a given function
  function [13:0] pulse_fix;
    input [2:0]  fn;
    input [13:0] val;
    begin
      if (fn == `WCP_FN_STEP && val > `WCP_PULSE_STEPMAX)
        pulse_fix = `WCP_PULSE_OFF;
      else
        pulse_fix = val;
    end
  endfunction

  // apb decode
  wire        setup_ph = psel & ~penable;
  // writes land only in the access cycle, never in setup
  wire        wr_en    = psel & penable & pwrite & pready;
  reg         hit;
  reg  [31:0] rd_val;

  // registers
  reg  [31:0] ctrl_r;
  reg  [2:0]  func_r;
  reg  [15:0] fmask_r;
  reg  [15:0] fval_r;
  reg         aforce_en_r;
  reg  [9:0]  aforce_val_r;
  reg  [13:0] pulse_r;
  reg  [13:0] tn1_r;
  reg  [13:0] cyc1_r;
  reg  [13:0] tn2_r;
  reg  [13:0] cyc2_r;
  reg  [9:0]  ymin_r;
  reg  [9:0]  ymax_r;
  reg  [9:0]  y0_r;

  // pulse machine
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [31:0] tick_cnt_r;
  reg         tick_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  // pause length latched at each on-to-off step, read back in status
  reg  [15:0] off_pulse_time_r;

  wire wc_en   = ctrl_r[`WCP_CTRL_WC_EN];
  wire auto_md = ctrl_r[`WCP_CTRL_AUTO];
  wire [3:0] version = ctrl_r[`WCP_CTRL_VER_HI:`WCP_CTRL_VER_LO];

  // force permission
  wire heat_ok = (func_r == `WCP_FN_OFF) | (func_r == `WCP_FN_3PT_SC) |
                 (func_r == `WCP_FN_3PT_CC) | (func_r == `WCP_FN_CONT);
  wire cool_ok = (func_r == `WCP_FN_OFF) | (func_r == `WCP_FN_SIG1) |
                 (func_r == `WCP_FN_TWOPT) | (func_r == `WCP_FN_3PT_SC) |
                 (func_r == `WCP_FN_3PT_CC) | (func_r == `WCP_FN_CONT);
  wire ana_ok  = ctrl_r[`WCP_CTRL_AOPT] & (version >= `WCP_MIN_VERSION) &
                 ~ctrl_r[`WCP_CTRL_ALLOC];

  // cooling demand, 0..1000 for 0 .. -100 %
  wire        neg     = corr_in[11];
  // two's complement magnitude; the most negative code is clamped below
  wire [11:0] mag     = ~corr_in + 12'h001;
  wire [9:0]  demand0 = ~neg ? 10'h000 :
                        (mag > {2'b00, `WCP_PCT_FULL}) ? `WCP_PCT_FULL :
                        mag[9:0];
  wire        suppress = auto_md & below_enable_temp;
  wire [9:0]  demand  = suppress ? 10'h000 : demand0;

  // timing in ticks: second set min cycle time is the minimum pause
  wire [14:0] ton_t   = to_ticks(pulse_r);
  wire [14:0] minimum_off_time_t = to_ticks(cyc2_r);
  wire [15:0] full_t  = {1'b0, ton_t} + {1'b0, minimum_off_time_t};
  // off = cycle/demand - on, so on/cycle = demand*on/(on+pmin)
  wire [25:0] num     = {10'h000, full_t} * 26'd1000;
  wire [25:0] cyc_t   = demand == 10'h000 ? 26'h0 :
                        num / {16'h0000, demand};
  wire [25:0] off_raw = cyc_t - {11'h000, ton_t};
  // no demand: a plain minimum pause, after which the sequencer goes idle
  wire [15:0] off_t   = (demand == 10'h000 ||
                         off_raw < {11'h000, minimum_off_time_t}) ?
                        {1'b0, minimum_off_time_t} :
                        (off_raw > 26'h00_FFFF) ? 16'hFFFF :
                        off_raw[15:0];

  // continuous output value in 0.1 %
  wire        pd_mode = ctrl_r[`WCP_CTRL_PSEL] ? (tn2_r == 14'h0000) :
                        (tn1_r == 14'h0000);
  // sign extended so a strong negative value saturates at zero
  wire [12:0] corr_x  = {corr_in[11], corr_in};
  wire [12:0] y_pd    = corr_x + {3'b000, `WCP_PCT_HALF} +
                        {3'b000, y0_r};
  wire [12:0] y_pi    = corr_x + {3'b000, y0_r};
  wire [12:0] y_sum   = pd_mode ? y_pd : y_pi;
  wire [9:0]  y_sat   = y_sum[12] ? 10'h000 :
                        (y_sum > {3'b000, `WCP_PCT_FULL}) ? `WCP_PCT_FULL :
                        y_sum[9:0];
  wire [9:0]  y_lim   = (y_sat < ymin_r) ? ymin_r :
                        (y_sat > ymax_r) ? ymax_r : y_sat;
  wire [9:0]  y_ana   = (aforce_en_r & ana_ok) ? aforce_val_r : y_lim;
  // live zero squeezes the span into 4..20 mA
  wire [13:0] y_x4    = {4'h0, y_ana} * 14'd4;
  wire [13:0] y_live  = y_x4 / 14'd5;
  wire [9:0]  ana_nxt = ctrl_r[`WCP_CTRL_LIVE0] ?
                        (`WCP_LIVE0_BASE + y_live[9:0]) : y_ana;

  // clamp a written percent to 100 %
  function [9:0] pct;
    input [31:0] v;
    begin
      pct = (v[15:0] > {6'h00, `WCP_PCT_FULL}) ? `WCP_PCT_FULL : v[9:0];
    end
  endfunction

  // read mux and address check
  always @* begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `WCP_CTRL_OFS:   rd_val = ctrl_r;
      `WCP_FUNC_OFS:   rd_val = {29'h0, func_r};
      `WCP_FMASK_OFS:  rd_val = {16'h0000, fmask_r};
      `WCP_FVAL_OFS:   rd_val = {16'h0000, fval_r};
      `WCP_AFORCE_OFS: rd_val = {15'h0, aforce_en_r, 6'h00, aforce_val_r};
      `WCP_PULSE_OFS:  rd_val = {18'h0, pulse_r};
      `WCP_PSET1_OFS:  rd_val = {2'b00, cyc1_r, 2'b00, tn1_r};
      `WCP_PSET2_OFS:  rd_val = {2'b00, cyc2_r, 2'b00, tn2_r};
      `WCP_YLIM_OFS:   rd_val = {6'h00, ymax_r, 6'h00, ymin_r};
      `WCP_YOFS_OFS:   rd_val = {22'h0, y0_r};
      `WCP_STAT_OFS:   rd_val = {off_pulse_time_r, 9'h000, ana_ok, cool_ok, heat_ok,
                                 cooling_pulse, 1'b0, state_r};
      `WCP_AOUT_OFS:   rd_val = {22'h0, analog_level};
      default: begin
        hit    = 1'b0;
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // bus answers: zero wait, data and error prepared in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_ph) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= ~hit;
      end
    end
  end

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r       <= `WCP_CTRL_RST;
      func_r       <= `WCP_FN_OFF;
      fmask_r      <= 16'h0000;
      fval_r       <= 16'h0000;
      aforce_en_r  <= 1'b0;
      aforce_val_r <= 10'h000;
      pulse_r      <= `WCP_PULSE_OFF;
      tn1_r        <= `WCP_TN_RST;
      cyc1_r       <= `WCP_TIME_RST;
      tn2_r        <= `WCP_TN_RST;
      cyc2_r       <= `WCP_TIME_RST;
      ymin_r       <= `WCP_YMIN_RST;
      ymax_r       <= `WCP_YMAX_RST;
      y0_r         <= `WCP_Y0_RST;
    end else if (wr_en) begin
      case (paddr)
        `WCP_CTRL_OFS: ctrl_r <= {20'h0, pwdata[11:8], 2'b00,
                                  pwdata[5:0]};
        `WCP_FUNC_OFS: begin
          func_r  <= pwdata[2:0];
          pulse_r <= pulse_fix(pwdata[2:0], pulse_r);
        end
        `WCP_FMASK_OFS: fmask_r <= pwdata[15:0];
        `WCP_FVAL_OFS:  fval_r  <= pwdata[15:0];
        `WCP_AFORCE_OFS: begin
          aforce_en_r  <= pwdata[16];
          aforce_val_r <= pct(pwdata);
        end
        `WCP_PULSE_OFS: begin
          if (func_r == `WCP_FN_STEP &&
              pwdata[13:0] > `WCP_PULSE_STEPMAX)
            pulse_r <= `WCP_PULSE_STEPMAX;
          else if (pwdata[15:0] > {2'b00, `WCP_PULSE_WCMAX})
            pulse_r <= `WCP_PULSE_WCMAX;
          else
            pulse_r <= pwdata[13:0];
        end
        `WCP_PSET1_OFS: begin
          tn1_r  <= pwdata[13:0];
          cyc1_r <= pwdata[29:16];
        end
        `WCP_PSET2_OFS: begin
          tn2_r  <= pwdata[13:0];
          cyc2_r <= pwdata[29:16];
        end
        `WCP_YLIM_OFS: begin
          ymin_r <= pct(pwdata);
          ymax_r <= pct({16'h0000, pwdata[31:16]});
        end
        `WCP_YOFS_OFS: y0_r <= pct(pwdata);
        default: ;
      endcase
    end
  end

  // scanning tick; a long divider so simulations may shorten it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // pulse sequencer, advanced only on ticks
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (tick_r) begin
      case (state_r)
        `WCP_ST_IDLE: begin
          if (wc_en && demand != 10'h000) begin
            state_nxt = `WCP_ST_ON;
            cnt_nxt   = {1'b0, ton_t} - 16'h0001;
          end
        end
        `WCP_ST_ON: begin
          if (cnt_r != 16'h0000)
            cnt_nxt = cnt_r - 16'h0001;
          else begin
            state_nxt = `WCP_ST_OFF;
            cnt_nxt   = off_t - 16'h0001;
          end
        end
        `WCP_ST_OFF: begin
          if (cnt_r != 16'h0000)
            cnt_nxt = cnt_r - 16'h0001;
          else if (wc_en && demand != 10'h000) begin
            state_nxt = `WCP_ST_ON;
            cnt_nxt   = {1'b0, ton_t} - 16'h0001;
          end else
            state_nxt = `WCP_ST_IDLE;
        end
        default: begin
          state_nxt = `WCP_ST_IDLE;
          cnt_nxt   = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= `WCP_ST_IDLE;
      cnt_r   <= 16'h0000;
      off_pulse_time_r  <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (tick_r && state_r == `WCP_ST_ON && cnt_r == 16'h0000)
        off_pulse_time_r <= off_t;
    end
  end

  // pins; forcing acts only where the function allows it
  wire [7:0] heat_norm = heat_sw_in;
  wire [7:0] cool_norm = wc_en ?
                         {cool_sw_in[7:1], state_nxt == `WCP_ST_ON} :
                         cool_sw_in;
  // force values replace the normal levels bit by bit
  wire [7:0] hmask = fmask_r[7:0] & {8{heat_ok}};
  wire [7:0] cmask = fmask_r[15:8] & {8{cool_ok}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heating_outputs   <= 8'h00;
      cooling_outputs   <= 4'h0;
      combined_io_lines <= 4'h0;
      analog_level      <= 10'h000;
      cooling_pulse     <= 1'b0;
    end else begin
      heating_outputs <= (heat_norm & ~hmask) | (fval_r[7:0] & hmask);
      {combined_io_lines, cooling_outputs} <=
        (cool_norm & ~cmask) | (fval_r[15:8] & cmask);
      analog_level  <= ana_nxt;
      cooling_pulse <= state_nxt == `WCP_ST_ON;
    end
  end

endmodule // wcp_pulse_output

/* wcp_valve_model.sv */
// cooling valve model: measures pulse and pause lengths in clocks
module wcp_valve_model (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // valve drive
  input  wire         cooling_pulse,
  // measured lengths of the last pulse, the last pause, pulse count
  output logic [15:0] on_len,
  output logic [15:0] off_len,
  output logic [15:0] rises
);
  logic [15:0] run_r;
  logic        prev_r;

  // a valve only sees levels, so lengths are taken between edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 16'h0;
      prev_r <= 1'b0;
      on_len <= 16'h0;
      off_len <= 16'h0;
      rises <= 16'h0;
    end else begin
      prev_r <= cooling_pulse;
      if (cooling_pulse != prev_r) begin
        run_r <= 16'h1;
        if (prev_r) on_len <= run_r;
        else off_len <= run_r;
        if (cooling_pulse) rises <= rises + 16'h1;
      end else begin
        run_r <= run_r + 16'h1;
      end
    end
  end
endmodule // wcp_valve_model

/* wcp_pulse_output_checker.sv */
// assertion checker for the water cooling pulse output
`include "wcp_defs.vh"
module wcp_pulse_output_checker #(
  parameter int TICK_CYCLES = 4
) (
  // clock, reset and apb
  input wire               pclk,
  input wire               presetn,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [7:0]         paddr,
  input wire [31:0]        pwdata,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               pslverr,
  // controller side
  input wire signed [11:0] corr_in,
  input wire               below_enable_temp,
  input wire [7:0]         heat_sw_in,
  input wire [7:0]         cool_sw_in,
  // pins
  input wire [7:0]         heating_outputs,
  input wire [3:0]         cooling_outputs,
  input wire [3:0]         combined_io_lines,
  input wire [9:0]         analog_level,
  input wire               cooling_pulse
);
  logic [31:0] ctrl_r, func_r, fmask_r, fval_r, afrc_r, ylim_r, pset2_r;
  logic [15:0] quiet_r, gap_r;
  logic        prev_r, seen_r;
  wire         wr = psel && penable && pwrite && pready;
  wire         heat_ok = func_r[2:0] inside {3'h0, 3'h3, 3'h4, 3'h5};
  wire         cool_ok = func_r[2:0] < 3'h6;
  wire         cause = ctrl_r[0] && !(ctrl_r[1] && below_enable_temp)
                       && corr_in < 0;
  wire [31:0]  ymn = {22'h0, ylim_r[9:0]};
  wire [31:0]  ymx = {22'h0, ylim_r[25:16]};
  wire [31:0]  lo = ctrl_r[3] ? 200 + ymn * 4 / 5 : ymn;
  wire [31:0]  hi = ctrl_r[3] ? 200 + ymx * 4 / 5 : ymx;
  wire [31:0]  minimum_off_time = ({18'h0, pset2_r[29:16]} * 8 + 4) / 5;

  // shadows of the registers, so the rules can be judged at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `WCP_CTRL_RST;
      func_r <= 32'h0;
      fmask_r <= 32'h0;
      fval_r <= 32'h0;
      afrc_r <= 32'h0;
      ylim_r <= {6'h0, `WCP_YMAX_RST, 6'h0, `WCP_YMIN_RST};
      pset2_r <= {2'h0, `WCP_TIME_RST, 2'h0, `WCP_TN_RST};
      quiet_r <= 16'h0;
      gap_r <= 16'h0;
      prev_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= cooling_pulse;
      quiet_r <= wr ? 16'h0 : quiet_r + {15'h0, quiet_r != 16'hFFFF};
      gap_r <= (cooling_pulse != prev_r) ? 16'h1
               : gap_r + {15'h0, gap_r != 16'hFFFF};
      if (cooling_pulse != prev_r) seen_r <= 1'b1;
      if (wr) begin
        case (paddr)
          `WCP_CTRL_OFS: ctrl_r <= pwdata;
          `WCP_FUNC_OFS: func_r <= pwdata;
          `WCP_FMASK_OFS: fmask_r <= pwdata;
          `WCP_FVAL_OFS: fval_r <= pwdata;
          `WCP_AFORCE_OFS: afrc_r <= pwdata;
          `WCP_YLIM_OFS: ylim_r <= pwdata;
          `WCP_PSET2_OFS: pset2_r <= pwdata;
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence change_s;
    seen_r && cooling_pulse != prev_r;
  endsequence
  sequence rise_s;
    seen_r && cooling_pulse && !prev_r;
  endsequence

  pready_up_a: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  err_unmapped_a: assert property (psel && penable && paddr > 8'h2C
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  tick_edge_a: assert property (change_s |-> gap_r % TICK_CYCLES == 0)
    else $error("pulse edge off tick grid");
  off_min_a: assert property (rise_s |-> gap_r >= minimum_off_time * TICK_CYCLES)
    else $error("pause below minimum off time");
  pulse_cause_a: assert property ($rose(cooling_pulse) |-> $past(cause))
    else $error("cooling pulse without cause");
  heat_force_a: assert property (quiet_r >= 2 && heat_ok
    && fmask_r[7:0] == 8'hFF |-> heating_outputs == fval_r[7:0])
    else $error("heating force not applied");
  cool_force_a: assert property (quiet_r >= 2 && cool_ok && !ctrl_r[0]
    && fmask_r[15:8] == 8'hFF
    |-> {combined_io_lines, cooling_outputs} == fval_r[15:8])
    else $error("cooling force not applied");
  level_range_a: assert property (quiet_r >= 3 && !afrc_r[16]
    |-> analog_level >= lo && analog_level <= hi)
    else $error("analog level outside limits");
endmodule // wcp_pulse_output_checker

bind wcp_pulse_output wcp_pulse_output_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .corr_in(corr_in),
  .below_enable_temp(below_enable_temp), .heat_sw_in(heat_sw_in),
  .cool_sw_in(cool_sw_in), .heating_outputs(heating_outputs),
  .cooling_outputs(cooling_outputs), .combined_io_lines(combined_io_lines),
  .analog_level(analog_level), .cooling_pulse(cooling_pulse)
);

/* wcp_pulse_output_tb_top.sv */
// self-checking testbench for the water cooling pulse output
`include "wcp_defs.vh"
module wcp_pulse_output_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              below_enable_temp, cooling_pulse, err_v;
  logic [7:0]        paddr, heat_sw_in, cool_sw_in, heating_outputs;
  logic [31:0]       pwdata, prdata, rd_v;
  logic signed [11:0] corr_in;
  logic [3:0]        cooling_outputs, combined_io_lines;
  logic [9:0]        analog_level;
  logic [15:0]       on_len, off_len, rises;
  int                failures, checks_done, base;

  wcp_pulse_output #(.TICK_CYCLES(TK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .corr_in(corr_in),
    .below_enable_temp(below_enable_temp), .heat_sw_in(heat_sw_in),
    .cool_sw_in(cool_sw_in), .heating_outputs(heating_outputs),
    .cooling_outputs(cooling_outputs), .combined_io_lines(combined_io_lines),
    .analog_level(analog_level), .cooling_pulse(cooling_pulse));
  wcp_valve_model valve (.pclk(pclk), .presetn(presetn),
    .cooling_pulse(cooling_pulse), .on_len(on_len), .off_len(off_len),
    .rises(rises));

  always #2.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e, got);
    checks_done++;
    if (got !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, got);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // bounded: a missing pulse shows up as a short count
  task automatic wait_rises(input int n);
    int k;
    k = 0;
    base = rises;
    while (rises < base + n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk("pulse count", base + n, rises);
  endtask
  task automatic alv(input logic signed [11:0] c, input [31:0] e);
    corr_in <= c;
    cyc(3);
    chk("analog level", e, analog_level);
  endtask

  task automatic t_regs();
    rd(`WCP_CTRL_OFS);
    chk("ctrl reset", `WCP_CTRL_RST, rd_v);
    rd(`WCP_YLIM_OFS);
    chk("ylim reset", {6'h0, `WCP_YMAX_RST, 6'h0, `WCP_YMIN_RST}, rd_v);
    rd(`WCP_PSET2_OFS);
    chk("pset2 reset", {2'h0, `WCP_TIME_RST, 2'h0, `WCP_TN_RST}, rd_v);
    wr(8'h30, 32'hFFFF_FFFF);
    chk("unmapped error", 32'h1, err_v);
    $display("test regs done");
  endtask
  task automatic t_force();
    bit ok_h;
    wr(`WCP_FMASK_OFS, 32'h0000_FFFF);
    wr(`WCP_FVAL_OFS, 32'h0000_C35A);
    for (int f = 0; f < 7; f++) begin
      wr(`WCP_FUNC_OFS, f);
      cyc(2);
      ok_h = f inside {0, 3, 4, 5};
      chk("heating", ok_h ? 8'h5A : heat_sw_in, heating_outputs);
      chk("cooling", f < 6 ? 8'hC3 : cool_sw_in,
          {combined_io_lines, cooling_outputs});
    end
    wr(`WCP_FMASK_OFS, 32'h0);
    $display("test force done");
  endtask
  task automatic t_analog();
    wr(`WCP_FUNC_OFS, `WCP_FN_CONT);
    wr(`WCP_PSET1_OFS, 32'h0032_0000);
    wr(`WCP_YLIM_OFS, 32'h0258_0064);
    wr(`WCP_YOFS_OFS, 32'h32);
    wr(`WCP_CTRL_OFS, 32'h0516);
    alv(12'sd100, 600);
    alv(-12'sd700, 100);
    alv(12'sd0, 550);
    wr(`WCP_CTRL_OFS, 32'h051E);
    alv(12'sd0, 640);
    wr(`WCP_CTRL_OFS, 32'h053E);
    alv(12'sd0, 280);
    wr(`WCP_CTRL_OFS, 32'h050C);
    wr(`WCP_AFORCE_OFS, 32'h0001_012C);
    alv(12'sd0, 440);
    wr(`WCP_CTRL_OFS, 32'h040C);
    alv(12'sd0, 640);
    rd(`WCP_AOUT_OFS);
    chk("aout read", 32'd640, rd_v);
    wr(`WCP_AFORCE_OFS, 32'h0);
    $display("test analog done");
  endtask
  task automatic t_cool();
    wr(`WCP_FUNC_OFS, `WCP_FN_3PT_SC);
    wr(`WCP_PULSE_OFS, 32'h2710);
    rd(`WCP_PULSE_OFS);
    chk("pulse clamp", `WCP_PULSE_WCMAX, rd_v);
    wr(`WCP_PULSE_OFS, 32'h1E);
    wr(`WCP_FUNC_OFS, `WCP_FN_STEP);
    rd(`WCP_PULSE_OFS);
    chk("pulse reconfig", `WCP_PULSE_OFF, rd_v);
    wr(`WCP_FUNC_OFS, `WCP_FN_3PT_SC);
    wr(`WCP_PULSE_OFS, 32'h1);
    wr(`WCP_PSET2_OFS, 32'h0004_0064);
    corr_in <= -12'sd1000;
    wr(`WCP_CTRL_OFS, 32'h3);
    wait_rises(3);
    chk("on time", 2 * TK, on_len);
    chk("off full", 7 * TK, off_len);
    corr_in <= -12'sd500;
    wait_rises(3);
    chk("off half", 16 * TK, off_len);
    wr(`WCP_PULSE_OFS, 32'h0);
    wait_rises(3);
    chk("on minimal", TK, on_len);
    chk("off minimal", 15 * TK, off_len);
    below_enable_temp <= 1'b1;
    cyc(30 * TK);
    base = rises;
    cyc(40 * TK);
    chk("auto below", base, rises);
    wr(`WCP_CTRL_OFS, 32'h1);
    wait_rises(2);
    wr(`WCP_CTRL_OFS, 32'h0);
    cyc(30 * TK);
    base = rises;
    cyc(40 * TK);
    chk("disabled", base, rises);
    $display("test cool done");
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    corr_in = 12'sd0;
    below_enable_temp = 1'b0;
    heat_sw_in = 8'hA5;
    cool_sw_in = 8'h96;
    failures = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    t_regs();
    t_force();
    t_analog();
    t_cool();
    close_out();
  end
  // the whole run needs well under a tenth of this span
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    close_out();
  end
endmodule // wcp_pulse_output_tb_top
